// ==== bench/quad_uart_pins_properties.sv ====
// concurrent checks on the quad uart pin block outputs
// assumes binding to quad_uart_pins, one clock, sync active-low reset
`timescale 1ns/10ps
`default_nettype none
module quad_uart_pins_chk (
  input wire logic CLK, // clock
  input wire logic RST_N, // reset
  input wire logic FIFO_STATUS_SELECT_N, // status select
  input wire logic [7:0] DATA_OUT, // data bus
  input wire logic [3:0] IR_ENABLE, // ir mode
  input wire logic [3:0] RX_INVERT, // rx invert
  input wire logic [3:0] RTS_CTRL, // rts request
  input wire logic [3:0] AUTO_RTS_EN, // auto rts
  input wire logic [3:0] RX, // rx lines
  input wire logic [3:0] RX_BIT, // decoded rx
  input wire logic [3:0] TX, // tx lines
  input wire logic [3:0] INFRARED_TX_OUT, // ir tx
  input wire logic [3:0] RTS_N, // rts out
  input wire logic [3:0] TX_READY_CH_N, // tx ready
  input wire logic [3:0] RX_READY_CH_N, // rx ready
  input wire logic TX_READY_N, // merged tx
  input wire logic RX_READY_N // merged rx
);
  tx_merge_a: assert property (@(posedge CLK) disable iff (!RST_N) TX_READY_N == &TX_READY_CH_N)
    else $error("merged tx ready wrong");
  rx_merge_a: assert property (@(posedge CLK) disable iff (!RST_N) RX_READY_N == &RX_READY_CH_N)
    else $error("merged rx ready wrong");
  status_read_a: assert property (@(posedge CLK) disable iff (!RST_N) !FIFO_STATUS_SELECT_N |=>
    DATA_OUT == {$past(RX_READY_CH_N), ~$past(TX_READY_CH_N)}) else $error("status byte wrong");
  reset_level_a: assert property (@(posedge CLK) !RST_N |=> TX == 4'hf && INFRARED_TX_OUT == 4'h0)
    else $error("reset line levels wrong");
  ir_same_a: assert property (@(posedge CLK) disable iff (!RST_N) $past(RST_N) |->
    ((TX ^ INFRARED_TX_OUT) & $past(IR_ENABLE)) == 4'h0) else $error("ir mode tx differs");
  start_bit_a: assert property (@(posedge CLK) disable iff (!RST_N) $fell(TX[0]) && !IR_ENABLE[0] |->
    !TX[0] [*8]) else $error("start bit too short");
  rx_decode_a: assert property (@(posedge CLK) disable iff (!RST_N) $past(RST_N) |-> RX_BIT ==
    (($past(RX) & ~$past(IR_ENABLE)) | (~($past(RX) ^ $past(RX_INVERT)) & $past(IR_ENABLE))))
    else $error("rx decode wrong");
  rts_follow_a: assert property (@(posedge CLK) disable iff (!RST_N) $past(RST_N) |->
    ((RTS_N ^ ~$past(RTS_CTRL)) & ~$past(AUTO_RTS_EN)) == 4'h0) else $error("rts wrong");
endmodule
`default_nettype wire

// ==== bench/serial_peer.sv ====
// remote serial equipment: idles rx lines, decodes frames of channel 0
// assumes BIT matches the block's bit time in clocks
`timescale 1ns/10ps
`default_nettype none
module serial_peer #(parameter int BIT = 16) (
  input wire logic clk, // clock
  input wire logic [3:0] tx, // device tx
  input wire logic [3:0] ir_mode, // per channel ir
  output logic [3:0] rx, // device rx
  output logic [7:0] rx_byte, // last byte on channel 0
  output logic got // toggles per byte
);
  assign rx = ~ir_mode;
  initial
  begin
    got = 1'b0;
    rx_byte = 8'h00;
    forever
    begin
      @(negedge tx[0]);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT) @(posedge clk);
        rx_byte[i] = tx[0];
      end
      got = ~got;
      repeat (BIT) @(posedge clk);
    end
  end
endmodule
`default_nettype wire

// ==== bench/test_quad_uart_pins.sv ====
// self-checking bench for quad_uart_pins with a serial peer
// assumes short bit time 16 clocks and fifo depth 8
`timescale 1ns/10ps
`default_nettype none
module test_quad_uart_pins;
  logic clk, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, sel_n = 1'b1, got, g0;
  logic [1:0] wr_ch = 2'd0, rd_ch = 2'd0;
  logic [7:0] wr_data = 8'h00, data_out, pbyte;
  logic [3:0] ir_en = 4'h0, rx_inv = 4'h0, rts_ctrl = 4'hf, auto_rts = 4'h1, rx_in_valid = 4'h0;
  logic [31:0] rx_in_data = 32'h0;
  logic [3:0] rx_in_ready, rx, rx_bit, tx, irtx, rts_n, txr_n, rxr_n;
  logic tx_ready_n_n, rx_ready_n_n;
  int error_cnt = 0, total_checks = 0;
  quad_uart_pins #(.CLKS_PER_BIT(16), .IR_PULSE_CLKS(3), .FIFO_DEPTH(8)) i_dut (.CLK(clk), .RST_N(rst_n),
    .WR_EN(wr_en), .WR_CH(wr_ch), .WR_DATA(wr_data), .RD_EN(rd_en), .RD_CH(rd_ch),
    .FIFO_STATUS_SELECT_N(sel_n), .DATA_OUT(data_out), .IR_ENABLE(ir_en), .RX_INVERT(rx_inv),
    .RTS_CTRL(rts_ctrl), .AUTO_RTS_EN(auto_rts), .RX_IN_DATA(rx_in_data), .RX_IN_VALID(rx_in_valid),
    .RX_IN_READY(rx_in_ready), .RX(rx), .RX_BIT(rx_bit), .TX(tx), .INFRARED_TX_OUT(irtx), .RTS_N(rts_n),
    .TX_READY_CH_N(txr_n), .RX_READY_CH_N(rxr_n), .TX_READY_N(tx_ready_n_n), .RX_READY_N(rx_ready_n_n));
  serial_peer #(.BIT(16)) i_peer (.clk(clk), .tx(tx), .ir_mode(ir_en), .rx(rx), .rx_byte(pbyte), .got(got));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got_v, input logic [7:0] exp);
    total_checks++;
    if (got_v !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t byte %h expected %h", $time, got_v, exp);
    end
  endtask
  task automatic chk_bits(input logic [3:0] got_v, input logic [3:0] exp);
    total_checks++;
    if (got_v !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t flags %b expected %b", $time, got_v, exp);
    end
  endtask
  task automatic wr(input logic [1:0] ch, input logic [7:0] base, input int n);
    wr_ch = ch;
    wr_en = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      wr_data = base + 8'(i);
      step(1);
    end
    wr_en = 1'b0;
  endtask
  task automatic rx_push(input int ch, input logic [7:0] base, input int n);
    rx_in_valid[ch] = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      rx_in_data[8*ch +: 8] = base + 8'(i);
      step(1);
    end
    rx_in_valid[ch] = 1'b0;
  endtask
  task automatic rd(input logic [1:0] ch, input logic [7:0] exp);
    rd_ch = ch;
    rd_en = 1'b1;
    step(1);
    rd_en = 1'b0;
    chk_byte(data_out, exp);
    step(1);
  endtask
  task automatic t_reset;
    chk_bits(tx, 4'hf);
    chk_bits(irtx, 4'h0);
    rst_n = 1'b1;
    step(2);
    chk_bits(txr_n, 4'h0);
    chk_bits(rxr_n, 4'hf);
    chk_bits({2'b00, tx_ready_n_n, rx_ready_n_n}, 4'h1);
    chk_bits(rx_bit, 4'hf);
    chk_bits(rx_in_ready, 4'hf);
  endtask
  task automatic t_status;
    rx_push(3, 8'h30, 1);
    step(2);
    sel_n = 1'b0;
    rd_en = 1'b1;
    rd_ch = 2'd3;
    wr_ch = 2'd1;
    step(1);
    chk_byte(data_out, 8'h7f);
    sel_n = 1'b1;
    rd_en = 1'b0;
    step(2);
    chk_bits({rxr_n[3], 2'b00, rx_ready_n_n}, 4'h0);
  endtask
  task automatic t_rx_fill;
    rx_push(0, 8'h40, 10);
    step(2);
    chk_bits(rts_n, 4'h1);
    chk_bits(rxr_n, 4'h6);
    for (int i = 0; i < 8; i++)
      rd(2'd0, 8'h40 + 8'(i));
    rd(2'd3, 8'h30);
    chk_bits(rxr_n, 4'hf);
    chk_bits({rts_n[0], 2'b00, rx_ready_n_n}, 4'h1);
  endtask
  task automatic t_tx;
    logic [7:0] n_ir = 8'h00;
    logic [7:0] n_tx = 8'h00;
    g0 = got;
    wr(2'd0, 8'ha5, 1);
    // ir pin pulses even in standard mode: 5 zero bits of 3 cycles
    for (int i = 0; i < 400 && got === g0; i++)
    begin
      step(1);
      n_ir = n_ir + 8'(irtx[0]);
    end
    if (got === g0)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t no frame seen by peer", $time);
      finish_test;
    end
    chk_byte(pbyte, 8'ha5);
    chk_byte(n_ir, 8'h0f);
    n_ir = 8'h00;
    ir_en = 4'h2;
    wr(2'd1, 8'h0f, 1);
    for (int i = 0; i < 200; i++)
    begin
      step(1);
      n_ir = n_ir + 8'(irtx[1]);
      n_tx = n_tx + 8'(tx[1]);
    end
    chk_byte(n_ir, 8'h0f);
    chk_byte(n_tx, 8'h0f);
    chk_bits({tx[0], tx[1], irtx[1], 1'b0}, 4'h8);
    ir_en = 4'h0;
  endtask
  task automatic t_tx_fill;
    wr(2'd2, 8'h50, 10);
    step(2);
    chk_bits(txr_n, 4'h4);
    sel_n = 1'b0;
    step(1);
    chk_byte(data_out, 8'hfb);
    sel_n = 1'b1;
    for (int i = 0; i < 400 && txr_n[2] !== 1'b0; i++)
      step(1);
    chk_bits({txr_n[2], 2'b00, tx_ready_n_n}, 4'h0);
  endtask
  task automatic t_decode;
    ir_en = 4'h3;
    rx_inv = 4'h5;
    step(2);
    chk_bits(rx_bit, 4'he);
    ir_en = 4'h0;
    rx_inv = 4'h0;
    rts_ctrl = 4'h5;
    step(2);
    chk_bits(rts_n, 4'ha);
    rts_ctrl = 4'hf;
  endtask
  initial
  begin
    step(2);
    t_reset;
    t_status;
    t_rx_fill;
    t_tx;
    t_tx_fill;
    t_decode;
    finish_test;
  end
endmodule
bind quad_uart_pins quad_uart_pins_chk i_chk (.CLK(CLK), .RST_N(RST_N), .FIFO_STATUS_SELECT_N(FIFO_STATUS_SELECT_N),
  .DATA_OUT(DATA_OUT), .IR_ENABLE(IR_ENABLE), .RX_INVERT(RX_INVERT), .RTS_CTRL(RTS_CTRL),
  .AUTO_RTS_EN(AUTO_RTS_EN), .RX(RX), .RX_BIT(RX_BIT), .TX(TX), .INFRARED_TX_OUT(INFRARED_TX_OUT),
  .RTS_N(RTS_N), .TX_READY_CH_N(TX_READY_CH_N), .RX_READY_CH_N(RX_READY_CH_N), .TX_READY_N(TX_READY_N),
  .RX_READY_N(RX_READY_N));
`default_nettype wire

// ==== hw/quad_uart_pins.sv ====
// four-channel uart pin block: ready merge, fifo status read, tx/ir lines, rx decode
// assumes synchronous inputs, an external receiver core feeding rx bytes, 100 MHz clock
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - merged tx ready low when any channel ready
// - merged rx ready low when any channel ready
// - status select low puts status on data
// - status low nibble inverted tx, high rx
// - status read ignores channel address
// - standard mode tx idles and resets high
// - infrared mode tx idles low, encoded
// - ir tx pins always encoded, idle low
// - optional rx inversion before ir decoder
module quad_uart_pins #(
  parameter int unsigned CLKS_PER_BIT = quad_uart_pkg::CLKS_PER_BIT,
  parameter int unsigned IR_PULSE_CLKS = quad_uart_pkg::IR_PULSE_CLKS,
  parameter int unsigned FIFO_DEPTH = quad_uart_pkg::FIFO_DEPTH
) (
  input wire logic CLK, // system clock
  input wire logic RST_N, // sync reset, active low
  input wire logic WR_EN, // host tx byte write strobe
  input wire logic [1:0] WR_CH, // channel of write
  input wire logic [7:0] WR_DATA, // tx byte
  input wire logic RD_EN, // host rx byte read strobe
  input wire logic [1:0] RD_CH, // channel of read
  input wire logic FIFO_STATUS_SELECT_N, // status read select, active low
  output logic [7:0] DATA_OUT, // host data bus
  input wire logic [3:0] IR_ENABLE, // per channel infrared mode
  input wire logic [3:0] RX_INVERT, // per channel ir rx inversion
  input wire logic [3:0] RTS_CTRL, // per channel rts request
  input wire logic [3:0] AUTO_RTS_EN, // per channel auto rts
  input wire logic [31:0] RX_IN_DATA, // rx bytes from receiver core
  input wire logic [3:0] RX_IN_VALID, // rx byte valid
  output logic [3:0] RX_IN_READY, // held high once out of reset, not driven by rx fifo room
  input wire logic [3:0] RX, // serial receive lines
  output logic [3:0] RX_BIT, // decoded receive level
  output logic [3:0] TX, // serial transmit lines
  output logic [3:0] INFRARED_TX_OUT, // ir transmit lines
  output logic [3:0] RTS_N, // request to send, active low
  output logic [3:0] TX_READY_CH_N, // per channel tx ready, active low
  output logic [3:0] RX_READY_CH_N, // per channel rx ready, active low
  output logic TX_READY_N, // merged tx ready, active low
  output logic RX_READY_N // merged rx ready, active low
);
  localparam int unsigned CW = $clog2(CLKS_PER_BIT + 1);
  logic [3:0] tx_full, rx_avail, rx_pop, tx_line, ir_line;
  logic [7:0] rx_head [4];
  logic [3:0] tx_rdy_n_d, rx_rdy_n_d, rx_bit_d, rts_n_d;
  logic [3:0] tx_rdy_n_q, rx_rdy_n_q, rx_bit_q, rts_n_q, rx_in_ready_q;
  logic [3:0] tx_q, ir_q;
  logic tx_all_n_d, rx_all_n_d, tx_all_n_q, rx_all_n_q;
  logic [7:0] data_out_d, data_out_q;

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_ch
      logic wr_hit, tf_ready, tf_valid, tf_pop, rf_ready;
      logic [7:0] tf_data;
      quad_uart_pkg::tx_state_t state_q, state_d;
      logic [9:0] shift_q, shift_d;
      logic [3:0] bit_q, bit_d;
      logic [CW-1:0] clk_q, clk_d;

      assign wr_hit = WR_EN & (WR_CH == 2'(ch));
      // writes to a full fifo are dropped
      sync_fifo #(.WIDTH(quad_uart_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk(CLK),
        .rst_n(RST_N),
        .in_valid(wr_hit),
        .in_ready(tf_ready),
        .in_data(WR_DATA),
        .out_valid(tf_valid),
        .out_ready(tf_pop),
        .out_data(tf_data)
      );
      sync_fifo #(.WIDTH(quad_uart_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk(CLK),
        .rst_n(RST_N),
        .in_valid(RX_IN_VALID[ch]),
        .in_ready(rf_ready),
        .in_data(RX_IN_DATA[ch*8 +: 8]),
        .out_valid(rx_avail[ch]),
        .out_ready(rx_pop[ch]),
        .out_data(rx_head[ch])
      );
      assign tx_full[ch] = ~tf_ready;
      assign rx_pop[ch] = RD_EN & FIFO_STATUS_SELECT_N & (RD_CH == 2'(ch));
      assign tf_pop = (state_q == quad_uart_pkg::TX_IDLE) & tf_valid;

      // bit-serial transmitter, start bit, 8 data lsb first, stop bit
      always_comb
      begin
        state_d = state_q;
        shift_d = shift_q;
        bit_d = bit_q;
        clk_d = clk_q;
        unique case (state_q)
          quad_uart_pkg::TX_IDLE:
          begin
            if (tf_valid)
            begin
              state_d = quad_uart_pkg::TX_SHIFT;
              shift_d = {1'b1, tf_data, 1'b0};
              bit_d = '0;
              clk_d = '0;
            end
          end
          quad_uart_pkg::TX_SHIFT:
          begin
            if (clk_q == CW'(CLKS_PER_BIT - 1))
            begin
              clk_d = '0;
              shift_d = {1'b1, shift_q[9:1]};
              bit_d = 4'(bit_q + 1'b1);
              if (bit_q == 4'(quad_uart_pkg::FRAME_BITS - 1))
              begin
                state_d = quad_uart_pkg::TX_IDLE;
              end
            end
            else
            begin
              clk_d = CW'(clk_q + 1'b1);
            end
          end
          default:
          begin
            state_d = quad_uart_pkg::TX_IDLE;
          end
        endcase
      end

      always_ff @(posedge CLK)
      begin
        if (!RST_N)
        begin
          state_q <= quad_uart_pkg::TX_IDLE;
          shift_q <= '1;
          bit_q <= '0;
          clk_q <= '0;
        end
        else
        begin
          state_q <= state_d;
          shift_q <= shift_d;
          bit_q <= bit_d;
          clk_q <= clk_d;
        end
      end

      // uart level idles high; ir pulse only in the first 3/16 of a zero bit
      assign tx_line[ch] = (state_q == quad_uart_pkg::TX_SHIFT) ? shift_q[0] : 1'b1;
      assign ir_line[ch] = (state_q == quad_uart_pkg::TX_SHIFT) & ~shift_q[0]
                           & (clk_q < CW'(IR_PULSE_CLKS));
      assign rx_rdy_n_d[ch] = ~rx_avail[ch];
      assign tx_rdy_n_d[ch] = tx_full[ch];
      // ir receive pulse is high-true after optional inversion
      assign rx_bit_d[ch] = IR_ENABLE[ch] ? ~(RX[ch] ^ RX_INVERT[ch]) : RX[ch];
      // auto rts drops request while the rx fifo is full; host sets RTS_CTRL first
      assign rts_n_d[ch] = ~(RTS_CTRL[ch] & ~(AUTO_RTS_EN[ch] & ~rf_ready));
      assign RX_IN_READY[ch] = rx_in_ready_q[ch];
    end
  endgenerate

  assign tx_all_n_d = &tx_rdy_n_d;
  assign rx_all_n_d = &rx_rdy_n_d;

  always_comb
  begin
    data_out_d = data_out_q;
    if (!FIFO_STATUS_SELECT_N)
    begin
      // no address used for this read
      data_out_d[quad_uart_pkg::STATUS_TX_LSB +: 4] = ~tx_rdy_n_q;
      data_out_d[quad_uart_pkg::STATUS_RX_LSB +: 4] = rx_rdy_n_q;
    end
    else if (RD_EN)
    begin
      data_out_d = rx_head[RD_CH];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      tx_q <= {4{quad_uart_pkg::TX_RESET_LEVEL}};
      ir_q <= {4{quad_uart_pkg::IR_IDLE_LEVEL}};
      tx_rdy_n_q <= {4{quad_uart_pkg::READY_N_RESET}};
      rx_rdy_n_q <= {4{quad_uart_pkg::READY_N_RESET}};
      tx_all_n_q <= quad_uart_pkg::READY_N_RESET;
      rx_all_n_q <= quad_uart_pkg::READY_N_RESET;
      rx_bit_q <= {4{quad_uart_pkg::RX_BIT_RESET}};
      rts_n_q <= {4{quad_uart_pkg::RTS_N_RESET}};
      rx_in_ready_q <= {4{quad_uart_pkg::RX_IN_READY_RESET}};
      data_out_q <= quad_uart_pkg::DATA_OUT_RESET;
    end
    else
    begin
      tx_q <= (IR_ENABLE & ir_line) | (~IR_ENABLE & tx_line);
      ir_q <= ir_line;
      tx_rdy_n_q <= tx_rdy_n_d;
      rx_rdy_n_q <= rx_rdy_n_d;
      tx_all_n_q <= tx_all_n_d;
      rx_all_n_q <= rx_all_n_d;
      rx_bit_q <= rx_bit_d;
      rts_n_q <= rts_n_d;
      rx_in_ready_q <= {4{1'b1}};
      data_out_q <= data_out_d;
    end
  end

  assign TX = tx_q;
  assign INFRARED_TX_OUT = ir_q;
  assign TX_READY_CH_N = tx_rdy_n_q;
  assign RX_READY_CH_N = rx_rdy_n_q;
  assign TX_READY_N = tx_all_n_q;
  assign RX_READY_N = rx_all_n_q;
  assign RX_BIT = rx_bit_q;
  assign RTS_N = rts_n_q;
  assign DATA_OUT = data_out_q;
endmodule
`default_nettype wire

// ==== hw/sync_fifo.sv ====
// parameterised synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module sync_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic in_valid, // write request
  output logic in_ready, // not full
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic out_valid, // not empty
  input wire logic out_ready, // read request
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [AW:0] count_q, count_d;
  logic push, pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready = (count_q != (AW + 1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem[rd_ptr_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb
  begin
    wr_ptr_d = push ? ptr_inc(wr_ptr_q) : wr_ptr_q;
    rd_ptr_d = pop ? ptr_inc(rd_ptr_q) : rd_ptr_q;
    count_d = count_q;
    if (push && !pop)
    begin
      count_d = (AW + 1)'(count_q + 1'b1);
    end
    else if (pop && !push)
    begin
      count_d = (AW + 1)'(count_q - 1'b1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_q] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ==== pkg/quad_uart_pkg.sv ====
// constants shared by the quad uart pin block and its fifo
// assumes a 100 MHz system clock and 8n1 framing
package quad_uart_pkg;
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned BAUD_RATE = 115_200;
  localparam int unsigned CLKS_PER_BIT = CLK_FREQ_HZ / BAUD_RATE;
  // ir pulse is 3/16 of a bit time, rounded down, at least one cycle
  localparam int unsigned IR_PULSE_CLKS = (CLKS_PER_BIT * 3 / 16) > 0 ? (CLKS_PER_BIT * 3 / 16) : 1;
  localparam int unsigned FRAME_BITS = 10;
  localparam int unsigned CHANNELS = 4;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned DATA_W = 8;
  // fifo_ready_status field layout
  localparam int unsigned STATUS_TX_LSB = 0;
  localparam int unsigned STATUS_RX_LSB = 4;
  // reset values
  localparam logic TX_RESET_LEVEL = 1'b1;
  localparam logic IR_IDLE_LEVEL = 1'b0;
  localparam logic READY_N_RESET = 1'b1;
  localparam logic [7:0] DATA_OUT_RESET = 8'h00;
  localparam logic RX_BIT_RESET = 1'b1;
  localparam logic RTS_N_RESET = 1'b1;
  localparam logic RX_IN_READY_RESET = 1'b0;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;
endpackage
